// ---- tcw_host_model.sv ----
`timescale 1ns/1ps

// host serial port model: hands over one assembled 40-bit command per pulse
module tcw_host_model
    import tcw_pkg::*;
(
    // clock
    core_clk,
    // command port
    cmd_valid,
    cmd_word
);
    input  wire logic             core_clk;
    output logic                  cmd_valid;
    output logic [CMD_W-1:0]      cmd_word;

    // idle lines start low; after a command they carry the inverse, never a stale copy
    initial begin
        cmd_valid = 1'b0;
        cmd_word  = '0;
    end

    // gap idles whole cycles first, so the host can be prompt or slow
    task automatic send(input logic [2:0] addr, input logic upd, input logic [13:0] fld,
                        input int gap);
        logic [CMD_W-1:0] w;
        w = '0;                                       // upper unused field stays zero
        w[ADDR_HI:ADDR_LO] = addr;                    // destination select
        w[UPD_BIT] = upd;
        w[13:0] = fld;
        w[POS_RSVD] = 1'b0;
        if (fld[12:11] == ACC_RSVD) begin             // reserved code never sent
            w[12] = 1'b0;
        end
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_word  = w;
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b0;
        cmd_word  = ~w;
    endtask
endmodule // tcw_host_model

// ---- tcw_pkg.sv ----
// test-control word: constants and carriers shared by the design and its tests
package tcw_pkg;

    // serial command layout
    localparam int          CMD_W      = 40;
    localparam int          ADDR_HI    = 39;
    localparam int          ADDR_LO    = 37;
    localparam int          UPD_BIT    = 36;
    localparam logic [2:0]  ADDR_TEST  = 3'h7;   // destination of this register
    localparam int          STORED_W   = 36;     // bits 35..0 are kept

    // field positions inside the stored word
    localparam int          POS_FORCE_IN  = 13;
    localparam int          POS_ACC_LO    = 11;
    localparam int          POS_Q_ROLL    = 10;
    localparam int          POS_FORCE_OUT = 9;
    localparam int          POS_FRC_BCLK  = 8;
    localparam int          POS_FRC_STB   = 7;
    localparam int          POS_FRC_I     = 6;
    localparam int          POS_FRC_Q     = 5;
    localparam int          POS_GEN_BYP   = 4;
    localparam int          POS_SCL_BYP   = 3;
    localparam int          POS_RSVD      = 2;
    localparam int          POS_WAIT_FILL = 1;
    localparam int          POS_OVF_DIS   = 0;

    // accumulator control codes
    localparam logic [1:0]  ACC_NORMAL = 2'h0;
    localparam logic [1:0]  ACC_OFF    = 2'h1;
    localparam logic [1:0]  ACC_CONT   = 2'h2;
    localparam logic [1:0]  ACC_RSVD   = 2'h3;

    // datapath widths and forced values
    localparam int          SAMPLE_W      = 16;
    localparam int          TRIG_W        = 20;
    localparam int          SCALE_W       = 18;
    localparam logic [15:0] FORCED_SAMPLE = 16'h8000;
    localparam logic [19:0] TRIG_ONE      = 20'hfffff;   // 0.fffff, just under unity
    localparam logic [17:0] SCALE_ONE     = 18'h10000;   // unity in 2.16 format

    // reset value of the stored word
    localparam logic [35:0] CFG_RESET = 36'h0;

    // stored test-control word
    typedef struct packed {
        logic [21:0] rsvd_hi;
        logic        force_in;
        logic [1:0]  acc_mode;
        logic        q_rollover;
        logic        force_out;
        logic        frc_bclk;
        logic        frc_stb;
        logic        frc_i;
        logic        frc_q;
        logic        gen_bypass;
        logic        scale_bypass;
        logic        rsvd_bit;
        logic        wait_fill;
        logic        ovf_disable;
    } tcw_cfg_t;

    // the four serial output pins
    typedef struct packed {
        logic bclk;
        logic stb;
        logic i;
        logic q;
    } tcw_pins_t;

endpackage

// ---- tcw_test_ctrl.sv ----
// How it works
// R1: commands whose address bits 39-37 are 111 load this register only.
// R2: update bit 0 applies this register alone; 1 applies every register together.
// R3: host writes zeros into unused bits 35-14.
// R4: input-forcing bit replaces every sample with 8000 hex.
// R5: accumulator code 00 clears the accumulator at each FIR output start.
// R6: accumulator code 01 disables accumulation completely.
// R7: code 10 never clears the accumulator; host never writes code 11.
// R8: rollover-strobe bit makes the quadrature pin pulse on phase rollover.
// R9: force-outputs bit drives the output pins from the four static bits.
// R10: under forcing, bit clock pin follows bit 8.
// R11: under forcing, word strobe pin follows bit 7.
// R12: under forcing, in-phase data pin follows bit 6.
// R13: under forcing, quadrature data pin follows bit 5.
// R14: generator bypass makes sine and cosine operands both 0.fffff.
// R15: scaling bypass forces a scale factor of exactly one.
// R16: host writes reserved bit 2 as zero while tests are enabled.
// R17: wait-for-fill suppresses output after reset until the data RAM is filled.
// R18: overflow-disable bit turns off arithmetic overflow protection.
// R19: all fields act only while the test-enable bit is set.
// R20: forcing outputs and input together leaves every output static. Here only the pins and the sample are fixed.
// R21: address and update bits are not stored nor read back.
`timescale 1ns/1ps

module tcw_test_ctrl
    import tcw_pkg::*;
(
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // assembled serial command from the control port
    input  wire logic                cmd_valid,
    input  wire logic [CMD_W-1:0]    cmd_word,
    // test enable from the phase-generator control word
    input  wire logic                test_enable,
    // readback request from the test port
    input  wire logic                read_control_word_instr,
    output logic      [STORED_W-1:0] rdbk_data_q,
    output logic                     rdbk_valid_q,
    // global update strobe to the other control words
    output logic                     update_all_q,
    // input sample path
    input  wire logic [SAMPLE_W-1:0] sample_in,
    output logic      [SAMPLE_W-1:0] sample_out_q,
    // fir accumulator control
    input  wire logic                fir_start,
    output logic                     acc_clear_q,
    output logic                     acc_enable_q,
    // mixer and scaling operands
    input  wire logic [TRIG_W-1:0]   sin_in,
    input  wire logic [TRIG_W-1:0]   cos_in,
    input  wire logic [SCALE_W-1:0]  scale_in,
    output logic      [TRIG_W-1:0]   mix_sin_q,
    output logic      [TRIG_W-1:0]   mix_cos_q,
    output logic      [SCALE_W-1:0]  scale_out_q,
    // overflow protection
    output logic                     ovf_protect_q,
    // output pins, normal levels in and final levels out
    input  wire tcw_pins_t           pins_in,
    input  wire logic                phase_rollover,
    output tcw_pins_t                pins_q,
    // ram fill tracking and static-mode flag
    input  wire logic                ram_filled,
    output logic                     out_hold_q,
    output logic                     static_mode_q
);

    tcw_cfg_t shadow_q;
    tcw_cfg_t active_q;
    logic     fill_seen_q;

    // command decode
    logic     cmd_hit;
    logic     cmd_upd;
    logic     apply_now;
    tcw_cfg_t cmd_cfg;

    assign cmd_hit = cmd_valid && (cmd_word[ADDR_HI:ADDR_LO] == ADDR_TEST); // see R1
    assign cmd_upd = cmd_valid && cmd_word[UPD_BIT];
    assign cmd_cfg = tcw_cfg_t'(cmd_word[STORED_W-1:0]); // see R21
    // a local-only load applies at once; any update-all command transfers everything
    assign apply_now = (cmd_hit && !cmd_upd) || cmd_upd; // see R2

    // shadow copy holds the last load until an update takes it over
    always_ff @(posedge core_clk) begin
        if (rst) begin
            shadow_q <= tcw_cfg_t'(CFG_RESET);
        end else if (cmd_hit) begin
            shadow_q <= cmd_cfg; // see R1
        end
    end

    // active copy; a hit with update set takes the new word, not the stale shadow
    always_ff @(posedge core_clk) begin
        if (rst) begin
            active_q <= tcw_cfg_t'(CFG_RESET);
        end else if (apply_now) begin
            active_q <= cmd_hit ? cmd_cfg : shadow_q; // see R2
        end
    end

    // pulse the other control words on an update-all command
    always_ff @(posedge core_clk) begin
        if (rst) begin
            update_all_q <= 1'b0;
        end else begin
            update_all_q <= cmd_upd; // see R2
        end
    end

    // effective fields, gated by the test enable
    logic       te_force_in;
    logic [1:0] te_acc;
    logic       te_roll;
    logic       te_force_out;
    logic       te_gen_byp;
    logic       te_scl_byp;
    logic       te_wait;
    logic       te_ovf_dis;

    assign te_force_in  = test_enable && active_q.force_in;      // see R19
    assign te_acc       = test_enable ? active_q.acc_mode : ACC_NORMAL; // see R19
    assign te_roll      = test_enable && active_q.q_rollover;
    assign te_force_out = test_enable && active_q.force_out;
    assign te_gen_byp   = test_enable && active_q.gen_bypass;
    assign te_scl_byp   = test_enable && active_q.scale_bypass;
    assign te_wait      = test_enable && active_q.wait_fill;
    assign te_ovf_dis   = test_enable && active_q.ovf_disable;

    // readback carries only the stored bits
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdbk_data_q  <= CFG_RESET;
            rdbk_valid_q <= 1'b0;
        end else begin
            rdbk_valid_q <= read_control_word_instr;
            if (read_control_word_instr) begin
                rdbk_data_q <= active_q; // see R21
            end
        end
    end

    // input sample forcing
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sample_out_q <= '0;
        end else begin
            sample_out_q <= te_force_in ? FORCED_SAMPLE : sample_in; // see R4
        end
    end

    // accumulator control; reserved code 11 behaves as normal, the host must avoid it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            acc_clear_q  <= 1'b0;
            acc_enable_q <= 1'b0;
        end else begin
            case (te_acc)
                ACC_OFF: begin
                    acc_clear_q  <= 1'b0;
                    acc_enable_q <= 1'b0; // see R6
                end
                ACC_CONT: begin
                    acc_clear_q  <= 1'b0; // see R7
                    acc_enable_q <= 1'b1;
                end
                default: begin
                    acc_clear_q  <= fir_start; // see R5
                    acc_enable_q <= 1'b1;
                end
            endcase
        end
    end

    // mixer and scale operands
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mix_sin_q   <= '0;
            mix_cos_q   <= '0;
            scale_out_q <= '0;
        end else begin
            mix_sin_q   <= te_gen_byp ? TRIG_ONE : sin_in; // see R14
            mix_cos_q   <= te_gen_byp ? TRIG_ONE : cos_in; // see R14
            scale_out_q <= te_scl_byp ? SCALE_ONE : scale_in; // see R15
        end
    end

    // overflow protection stays on unless a test turns it off
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ovf_protect_q <= 1'b1;
        end else begin
            ovf_protect_q <= !te_ovf_dis; // see R18
        end
    end

    // fill tracking restarts at reset, so stale RAM words are never shown
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fill_seen_q <= 1'b0;
        end else if (ram_filled) begin
            fill_seen_q <= 1'b1;
        end
    end

    logic hold;
    assign hold = te_wait && !fill_seen_q && !ram_filled; // see R17

    always_ff @(posedge core_clk) begin
        if (rst) begin
            out_hold_q <= 1'b0;
        end else begin
            out_hold_q <= hold; // see R17
        end
    end

    // output pins: forcing wins over hold, hold over rollover, rollover over normal
    tcw_pins_t pins_d;
    always_comb begin
        pins_d = pins_in;
        if (te_force_out) begin
            pins_d.bclk = active_q.frc_bclk; // see R10
            pins_d.stb  = active_q.frc_stb;  // see R11
            pins_d.i    = active_q.frc_i;    // see R12
            pins_d.q    = active_q.frc_q;    // see R13, see R9
        end else if (hold) begin
            pins_d = '0; // see R17
        end else if (te_roll) begin
            pins_d.q = phase_rollover; // see R8
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pins_q <= '0;
        end else begin
            pins_q <= pins_d;
        end
    end

    // both forcing bits together: pins and sample are fixed; mixer operands and acc_clear_q still follow their inputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            static_mode_q <= 1'b0;
        end else begin
            static_mode_q <= te_force_out && te_force_in; // see R20
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_hit_loads_active: assert property ( // see R1
        cmd_valid && cmd_word[ADDR_HI:ADDR_LO] == ADDR_TEST && !cmd_word[UPD_BIT]
        |=> active_q == $past(cmd_word[STORED_W-1:0]))
        else $error("local load did not reach the active word");

    chk_miss_keeps_active: assert property ( // see R2
        !(cmd_valid && (cmd_word[ADDR_HI:ADDR_LO] == ADDR_TEST || cmd_word[UPD_BIT]))
        |=> $stable(active_q))
        else $error("active word changed without a command");

    chk_update_all_pulse: assert property ( // see R2
        cmd_valid && cmd_word[UPD_BIT] |=> update_all_q && active_q == $past(
            cmd_word[ADDR_HI:ADDR_LO] == ADDR_TEST ? cmd_word[STORED_W-1:0] : shadow_q))
        else $error("update-all did not transfer the word");

    chk_force_sample: assert property ( // see R4
        test_enable && active_q.force_in |=> sample_out_q == FORCED_SAMPLE)
        else $error("forced sample missing");

    chk_sample_pass: assert property ( // see R19
        !test_enable |=> sample_out_q == $past(sample_in))
        else $error("sample altered with tests disabled");

    chk_acc_modes: assert property ( // see R5
        test_enable && active_q.acc_mode == ACC_NORMAL && fir_start |=> acc_clear_q && acc_enable_q)
        else $error("normal mode did not clear accumulator");

    chk_acc_off: assert property ( // see R6
        test_enable && active_q.acc_mode == ACC_OFF |=> !acc_enable_q && !acc_clear_q)
        else $error("accumulator not disabled");

    chk_acc_cont: assert property ( // see R7
        test_enable && active_q.acc_mode == ACC_CONT |=> !acc_clear_q)
        else $error("continuous mode cleared accumulator");

    chk_force_pins: assert property ( // see R9
        test_enable && active_q.force_out |=> pins_q == $past({active_q.frc_bclk,
            active_q.frc_stb, active_q.frc_i, active_q.frc_q}))
        else $error("forced pin levels wrong");

    chk_rollover_q: assert property ( // see R8
        test_enable && active_q.q_rollover && !active_q.force_out && !hold
        |=> pins_q.q == $past(phase_rollover))
        else $error("quadrature pin not showing rollover");

    chk_trig_bypass: assert property ( // see R14
        test_enable && active_q.gen_bypass |=> mix_sin_q == TRIG_ONE && mix_cos_q == TRIG_ONE)
        else $error("generator bypass not applied");

    chk_scale_bypass: assert property ( // see R15
        test_enable && active_q.scale_bypass |=> scale_out_q == SCALE_ONE)
        else $error("scale factor not unity");

    chk_fill_hold: assert property ( // see R17
        test_enable && active_q.wait_fill && !fill_seen_q && !ram_filled
        && !active_q.force_out |=> out_hold_q && pins_q == '0)
        else $error("output not held before fill");

    chk_ovf_protect: assert property ( // see R18
        ovf_protect_q == !$past(test_enable && active_q.ovf_disable))
        else $error("overflow protection level wrong");

    chk_static_mode: assert property ( // see R20
        test_enable && active_q.force_out && active_q.force_in
        |=> static_mode_q && sample_out_q == FORCED_SAMPLE)
        else $error("static mode not reached");

    chk_readback: assert property ( // see R21
        read_control_word_instr |=> rdbk_valid_q && rdbk_data_q == $past(active_q))
        else $error("readback wrong");

    // the other words must only be strobed by a command carrying the update bit
    chk_update_quiet: assert property ( // see R2
        !(cmd_valid && cmd_word[UPD_BIT]) |=> !update_all_q)
        else $error("global update without update bit");

    // once the fill has been seen, only a reset may bring the hold back
    chk_hold_release: assert property ( // see R17
        fill_seen_q |=> !out_hold_q)
        else $error("output held after ram fill");

    // with tests disabled every pin follows its normal level
    chk_pins_normal: assert property ( // see R19
        !test_enable |=> pins_q == $past(pins_in))
        else $error("pins altered with tests disabled");

    // accumulation may only stop in the no-accumulation code
    chk_acc_enable: assert property ( // see R6
        !(test_enable && active_q.acc_mode == ACC_OFF) |=> acc_enable_q)
        else $error("accumulator disabled outside its code");

    cov_local_load: cover property (cmd_hit && !cmd_upd);
    cov_update_all: cover property (cmd_hit ##[1:20] cmd_valid && cmd_upd && !cmd_hit);
    cov_static: cover property (static_mode_q);
    cov_fill_release: cover property (out_hold_q ##1 !out_hold_q);
    cov_rollover_pin: cover property (te_roll && phase_rollover && !te_force_out);

endmodule // tcw_test_ctrl

// ---- tcw_test_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; $display("BAD %0t %s", $time, m); end end

module tcw_test_ctrl_tb_top
    import tcw_pkg::*;
;
    // one field setting and the outputs it should give
    typedef struct packed {
        logic [13:0]         fld;
        logic                ten;
        logic [SAMPLE_W-1:0] smp;
        logic                acc;
        logic [TRIG_W-1:0]   sn;
        logic [TRIG_W-1:0]   cs;
        logic [SCALE_W-1:0]  scl;
        logic                ovf;
        tcw_pins_t           pins;
    } tcw_row_t;

    // fixed normal-path inputs, all distinct from the forced constants
    localparam logic [SAMPLE_W-1:0] SMP = 16'h1234;
    localparam logic [TRIG_W-1:0]   SN  = 20'h12345;
    localparam logic [TRIG_W-1:0]   CS  = 20'h54321;
    localparam logic [SCALE_W-1:0]  SC  = 18'h0abcd;
    localparam logic [3:0]          PN  = 4'h2;
    localparam tcw_row_t ROWS [10] = '{
        '{14'h2000, 1'b1, FORCED_SAMPLE, 1'b1, SN, CS, SC, 1'b1, PN},
        '{14'h2000, 1'b0, SMP, 1'b1, SN, CS, SC, 1'b1, PN},
        '{14'h0000, 1'b1, SMP, 1'b1, SN, CS, SC, 1'b1, PN},
        '{14'h0800, 1'b1, SMP, 1'b0, SN, CS, SC, 1'b1, PN},
        '{14'h1000, 1'b1, SMP, 1'b1, SN, CS, SC, 1'b1, PN},
        '{14'h0010, 1'b1, SMP, 1'b1, TRIG_ONE, TRIG_ONE, SC, 1'b1, PN},
        '{14'h0008, 1'b1, SMP, 1'b1, SN, CS, SCALE_ONE, 1'b1, PN},
        '{14'h0001, 1'b1, SMP, 1'b1, SN, CS, SC, 1'b0, PN},
        '{14'h0340, 1'b1, SMP, 1'b1, SN, CS, SC, 1'b1, 4'ha},
        '{14'h02a0, 1'b1, SMP, 1'b1, SN, CS, SC, 1'b1, 4'h5}
    };

    logic                core_clk, rst, cmd_valid, test_enable, read_control_word_instr;
    logic [CMD_W-1:0]    cmd_word;
    logic [STORED_W-1:0] rdbk_data_q;
    logic                rdbk_valid_q, update_all_q, fir_start, acc_clear_q, acc_enable_q;
    logic [SAMPLE_W-1:0] sample_in, sample_out_q;
    logic [TRIG_W-1:0]   sin_in, cos_in, mix_sin_q, mix_cos_q;
    logic [SCALE_W-1:0]  scale_in, scale_out_q;
    logic                ovf_protect_q, phase_rollover, ram_filled, out_hold_q, static_mode_q;
    tcw_pins_t           pins_in, pins_q;
    int                  n_mismatch, tests_run, cyc;

    tcw_test_ctrl tcw_test_ctrl_i (.core_clk, .rst, .cmd_valid, .cmd_word, .test_enable,
        .read_control_word_instr, .rdbk_data_q, .rdbk_valid_q, .update_all_q, .sample_in,
        .sample_out_q, .fir_start, .acc_clear_q, .acc_enable_q, .sin_in, .cos_in, .scale_in,
        .mix_sin_q, .mix_cos_q, .scale_out_q, .ovf_protect_q, .pins_in, .phase_rollover,
        .pins_q, .ram_filled, .out_hold_q, .static_mode_q);
    tcw_host_model tcw_host_model_i (.core_clk, .cmd_valid, .cmd_word);

    // 125 mhz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // inputs always move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic load(input logic [2:0] a, input logic u, input logic [13:0] f);
        tcw_host_model_i.send(a, u, f, 0);
    endtask

    // one-cycle readback request; answer stands right after the taking edge
    task automatic readback(input logic [STORED_W-1:0] exp);
        read_control_word_instr = 1'b1;
        tick(1);
        read_control_word_instr = 1'b0;
        `CHK(rdbk_valid_q, 1'b1, "readback valid")
        `CHK(rdbk_data_q, exp, "readback data")
        tick(1);
        `CHK(rdbk_valid_q, 1'b0, "readback valid stuck")
    endtask

    initial begin
        logic [1:0] m;
        {rst, test_enable, read_control_word_instr, fir_start, phase_rollover} = 5'b11000;
        {sample_in, sin_in, cos_in, scale_in, pins_in, ram_filled} = {SMP, SN, CS, SC, PN, 1'b1};
        tick(5);
        rst = 1'b0;
        `CHK(ovf_protect_q, 1'b1, "reset protection")
        readback(CFG_RESET);
        // table of field settings, one loop
        foreach (ROWS[k]) begin
            test_enable = ROWS[k].ten;
            load(3'h7, 1'b0, ROWS[k].fld);
            tick(2);
            `CHK(sample_out_q, ROWS[k].smp, "sample path")
            `CHK(acc_enable_q, ROWS[k].acc, "accumulator enable")
            `CHK({mix_sin_q, mix_cos_q}, {ROWS[k].sn, ROWS[k].cs}, "mixer operands")
            `CHK(scale_out_q, ROWS[k].scl, "scale factor")
            `CHK(ovf_protect_q, ROWS[k].ovf, "overflow protection")
            `CHK(pins_q, ROWS[k].pins, "output pins")
        end
        test_enable = 1'b1;
        // update bit: local load gives no global strobe, global load one pulse
        load(3'h7, 1'b0, 14'h0000);
        `CHK(update_all_q, 1'b0, "spurious global update")
        load(3'h7, 1'b1, 14'h0000);
        `CHK(update_all_q, 1'b1, "global update missing")
        tick(1);
        `CHK(update_all_q, 1'b0, "global update too long")
        // a foreign address with the update bit strobes the others and applies this word's shadow
        load(3'h6, 1'b1, 14'h2000);
        `CHK(update_all_q, 1'b1, "foreign update missing")
        // other address must not reach this word
        load(3'h6, 1'b0, 14'h2000);
        tick(2);
        `CHK(sample_out_q, SMP, "foreign address loaded")
        // readback omits address and update bits
        load(3'h7, 1'b1, 14'h2341);
        tick(2);
        readback(36'h000002341);
        // accumulator clearing per fir output: cleared in 00, never in 10
        for (int j = 0; j < 2; j++) begin
            m = j[0] ? ACC_CONT : ACC_NORMAL;
            load(3'h7, 1'b0, {1'b0, m, 11'h000});
            tick(1);
            fir_start = 1'b1;
            tick(1);
            fir_start = 1'b0;
            `CHK(acc_clear_q, ~j[0], "accumulator clear")
        end
        // rollover strobe on the quadrature pin
        load(3'h7, 1'b0, 14'h0400);
        phase_rollover = 1'b1;
        tick(2);
        `CHK(pins_q.q, 1'b1, "rollover strobe")
        phase_rollover = 1'b0;
        tick(2);
        `CHK(pins_q.q, 1'b0, "rollover strobe stuck")
        // forcing outputs and input together: static
        load(3'h7, 1'b0, 14'h2200);
        tick(2);
        `CHK({static_mode_q, pins_q}, 5'h10, "static mode")
        // wait for ram fill after a fresh reset
        rst = 1'b1;
        ram_filled = 1'b0;
        tick(2);
        rst = 1'b0;
        load(3'h7, 1'b0, 14'h0002);
        tick(3);
        `CHK({out_hold_q, pins_q}, 5'h10, "output not held")
        ram_filled = 1'b1;
        tick(2);
        `CHK({out_hold_q, pins_q}, {1'b0, PN}, "hold not released")
        give_verdict();
    end
endmodule // tcw_test_ctrl_tb_top
